//--- logic/ccdo_core.sv
// execution slice for watchdog clear, call, invert, clears and decrements
// assumes the register file is read combinationally at I_REG_ADDR and a
// write strobe is taken on the next clock edge; one instruction cycle per clock, two for a call or a taken skip
`timescale 1ns/1ps
module ccdo_core
  import ccdo_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire logic I_WATCHDOG_CLEAR_OP,
  input wire logic I_CALL_OP,
  input wire logic I_INVERT_REGISTER_OP,
  input wire logic I_CLEAR_REGISTER_OP,
  input wire logic I_DECREMENT_OP,
  input wire logic I_CLEAR_ACCUMULATOR_OP,
  input wire logic I_DECREMENT_SKIP_ZERO_OP,
  input wire logic I_DEST,
  input wire logic [6:0] I_REG_ADDR,
  input wire logic [10:0] I_CALL_TARGET,
  input wire logic [7:0] I_REG_RDATA,
  input wire logic [7:0] I_PROGRAM_PAGE_LATCH,
  input wire logic [12:0] I_PC,
  output logic O_READY,
  output logic O_DISCARD_NEXT,
  output logic O_REG_WE,
  output logic [6:0] O_REG_WADDR,
  output logic [7:0] O_REG_WDATA,
  output logic [7:0] O_ACCUMULATOR,
  output logic O_ZERO_FLAG_WE,
  output logic O_ZERO_FLAG,
  output logic O_WATCHDOG_CLEAR,
  output logic O_WATCHDOG_EXPIRY_FLAG_SET,
  output logic O_SLEEP_ENTERED_FLAG_SET,
  output logic O_STACK_PUSH,
  output logic [12:0] O_STACK_HEAD,
  output logic O_PC_LOAD,
  output logic [12:0] O_PC_NEXT
);
  ccdo_alu_if alu_bus ();
  ccdo_op_t op;
  ccdo_state_t state_q, state_d;
  logic go;
  logic ready_q, ready_d;
  logic discard_q, discard_d;
  logic reg_we_q, reg_we_d;
  logic [6:0] reg_waddr_q, reg_waddr_d;
  logic [7:0] reg_wdata_q, reg_wdata_d;
  logic [7:0] acc_q, acc_d;
  logic zwe_q, zwe_d;
  logic zflag_q, zflag_d;
  logic watchdog_clr_q, watchdog_clr_d;
  logic expiry_set_q, expiry_set_d;
  logic sleep_set_q, sleep_set_d;
  logic push_q, push_d;
  logic [12:0] head_q, head_d;
  logic pc_load_q, pc_load_d;
  logic [12:0] pc_next_q, pc_next_d;

  ccdo_opdec u_opdec (
    .i_strobes({I_DECREMENT_SKIP_ZERO_OP, I_CLEAR_ACCUMULATOR_OP, I_DECREMENT_OP,
      I_CLEAR_REGISTER_OP, I_INVERT_REGISTER_OP, I_CALL_OP, I_WATCHDOG_CLEAR_OP}),
    .o_op(op)
  );

  ccdo_alu u_alu (
    .alu(alu_bus.unit)
  );

  // requests are only taken in the execute state; a second-cycle fill ignores them
  assign go = I_VALID && (state_q == CCDO_ST_EXEC);
  assign alu_bus.op = go ? op : CCDO_OP_NONE;
  assign alu_bus.operand = I_REG_RDATA;

  always_comb begin
    state_d = CCDO_ST_EXEC;
    ready_d = 1'b1;
    discard_d = 1'b0;
    reg_we_d = 1'b0;
    reg_waddr_d = I_REG_ADDR;
    reg_wdata_d = alu_bus.result;
    acc_d = acc_q;
    zwe_d = 1'b0;
    zflag_d = zflag_q;
    watchdog_clr_d = 1'b0;
    expiry_set_d = 1'b0;
    sleep_set_d = 1'b0;
    push_d = 1'b0;
    head_d = head_q;
    pc_load_d = 1'b0;
    pc_next_d = pc_next_q;
    unique case (state_q)
      CCDO_ST_EXEC: begin
        if (go) begin
          unique case (op)
            CCDO_OP_WATCHDOG_CLEAR: begin
              watchdog_clr_d = 1'b1;
              expiry_set_d = 1'b1;
              sleep_set_d = 1'b1;
            end
            CCDO_OP_CALL: begin
              push_d = 1'b1;
              head_d = I_PC + CCDO_PC_ONE;
              pc_load_d = 1'b1;
              pc_next_d = {I_PROGRAM_PAGE_LATCH[CCDO_PAGE_HI:CCDO_PAGE_LO],
                I_CALL_TARGET};
              state_d = CCDO_ST_CALL_FILL;
              ready_d = 1'b0;
            end
            CCDO_OP_CLEAR_ACC: begin
              acc_d = alu_bus.result;
              zwe_d = 1'b1;
              zflag_d = alu_bus.zero;
            end
            CCDO_OP_CLEAR_REG: begin
              reg_we_d = 1'b1;
              zwe_d = 1'b1;
              zflag_d = alu_bus.zero;
            end
            CCDO_OP_INVERT, CCDO_OP_DECREMENT, CCDO_OP_DEC_SKIP: begin
              if (I_DEST == CCDO_DEST_REG) begin
                reg_we_d = 1'b1;
              end else begin
                acc_d = alu_bus.result;
              end
              if (op != CCDO_OP_DEC_SKIP) begin
                zwe_d = 1'b1;
                zflag_d = alu_bus.zero;
              end else if (alu_bus.zero) begin
                discard_d = 1'b1;
                state_d = CCDO_ST_SKIP_NOP;
                ready_d = 1'b0;
              end
            end
            default: begin
              state_d = CCDO_ST_EXEC;
            end
          endcase
        end
      end
      // second cycles carry no effects: flags and registers stay as they are
      CCDO_ST_CALL_FILL: begin
        state_d = CCDO_ST_EXEC;
      end
      CCDO_ST_SKIP_NOP: begin
        state_d = CCDO_ST_EXEC;
      end
      default: begin
        state_d = CCDO_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_q <= CCDO_ST_EXEC;
      ready_q <= 1'b1;
      discard_q <= 1'b0;
      reg_we_q <= 1'b0;
      reg_waddr_q <= '0;
      reg_wdata_q <= CCDO_ZERO_BYTE;
      acc_q <= CCDO_W_RESET;
      zwe_q <= 1'b0;
      zflag_q <= 1'b0;
      watchdog_clr_q <= 1'b0;
      expiry_set_q <= 1'b0;
      sleep_set_q <= 1'b0;
      push_q <= 1'b0;
      head_q <= CCDO_PC_RESET;
      pc_load_q <= 1'b0;
      pc_next_q <= CCDO_PC_RESET;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      discard_q <= discard_d;
      reg_we_q <= reg_we_d;
      reg_waddr_q <= reg_waddr_d;
      reg_wdata_q <= reg_wdata_d;
      acc_q <= acc_d;
      zwe_q <= zwe_d;
      zflag_q <= zflag_d;
      watchdog_clr_q <= watchdog_clr_d;
      expiry_set_q <= expiry_set_d;
      sleep_set_q <= sleep_set_d;
      push_q <= push_d;
      head_q <= head_d;
      pc_load_q <= pc_load_d;
      pc_next_q <= pc_next_d;
    end
  end

  assign O_READY = ready_q;
  assign O_DISCARD_NEXT = discard_q;
  assign O_REG_WE = reg_we_q;
  assign O_REG_WADDR = reg_waddr_q;
  assign O_REG_WDATA = reg_wdata_q;
  assign O_ACCUMULATOR = acc_q;
  assign O_ZERO_FLAG_WE = zwe_q;
  assign O_ZERO_FLAG = zflag_q;
  assign O_WATCHDOG_CLEAR = watchdog_clr_q;
  assign O_WATCHDOG_EXPIRY_FLAG_SET = expiry_set_q;
  assign O_SLEEP_ENTERED_FLAG_SET = sleep_set_q;
  assign O_STACK_PUSH = push_q;
  assign O_STACK_HEAD = head_q;
  assign O_PC_LOAD = pc_load_q;
  assign O_PC_NEXT = pc_next_q;
endmodule

//--- logic/ccdo_pkg.sv
// constants and types shared by the clear/call/decrement execution slice
// assumes one instruction cycle per clock of the core instruction clock
package ccdo_pkg;
  localparam int CCDO_DATA_W = 8;
  localparam int CCDO_ADDR_W = 7;
  localparam int CCDO_PC_W = 13;
  localparam int CCDO_K_W = 11;
  localparam int CCDO_PAGE_LO = 3;
  localparam int CCDO_PAGE_HI = 4;
  localparam logic [7:0] CCDO_ZERO_BYTE = 8'h00;
  localparam logic [7:0] CCDO_ONE_BYTE = 8'h01;
  localparam logic [12:0] CCDO_PC_ONE = 13'h0001;
  localparam logic [12:0] CCDO_PC_RESET = 13'h0000;
  localparam logic [7:0] CCDO_W_RESET = 8'h00;
  localparam logic CCDO_DEST_ACC = 1'b0;
  localparam logic CCDO_DEST_REG = 1'b1;

  typedef enum logic [2:0] {
    CCDO_OP_NONE,
    CCDO_OP_WATCHDOG_CLEAR,
    CCDO_OP_CALL,
    CCDO_OP_INVERT,
    CCDO_OP_CLEAR_REG,
    CCDO_OP_DECREMENT,
    CCDO_OP_CLEAR_ACC,
    CCDO_OP_DEC_SKIP
  } ccdo_op_t;

  typedef enum logic [1:0] {
    CCDO_ST_EXEC,
    CCDO_ST_CALL_FILL,
    CCDO_ST_SKIP_NOP
  } ccdo_state_t;
endpackage

//--- logic/ccdo_alu_if.sv
// operand and result bundle between the core sequencer and its data unit
// assumes the sequencer drives operands and the data unit answers combinationally
`timescale 1ns/1ps
interface ccdo_alu_if;
  import ccdo_pkg::*;
  ccdo_op_t op;
  logic [7:0] operand;
  logic [7:0] result;
  logic zero;
  logic writes;
  modport core (output op, output operand, input result, input zero, input writes);
  modport unit (input op, input operand, output result, output zero, output writes);
endinterface

//--- logic/ccdo_alu.sv
// data unit: result byte and zero test for the register-operand operations
// assumes operands are stable for the whole cycle
`timescale 1ns/1ps
module ccdo_alu
  import ccdo_pkg::*;
(
  ccdo_alu_if.unit alu
);
  always_comb begin
    alu.result = CCDO_ZERO_BYTE;
    alu.writes = 1'b0;
    unique case (alu.op)
      CCDO_OP_INVERT: begin
        alu.result = ~alu.operand;
        alu.writes = 1'b1;
      end
      CCDO_OP_DECREMENT, CCDO_OP_DEC_SKIP: begin
        alu.result = alu.operand - CCDO_ONE_BYTE;
        alu.writes = 1'b1;
      end
      CCDO_OP_CLEAR_REG, CCDO_OP_CLEAR_ACC: begin
        alu.result = CCDO_ZERO_BYTE;
        alu.writes = 1'b1;
      end
      default: begin
        alu.result = CCDO_ZERO_BYTE;
        alu.writes = 1'b0;
      end
    endcase
    alu.zero = (alu.result == CCDO_ZERO_BYTE);
  end
endmodule

//--- logic/ccdo_opdec.sv
// operation decoder: turns one-hot request strobes into an operation code
// assumes at most one strobe is raised per instruction cycle
`timescale 1ns/1ps
module ccdo_opdec
  import ccdo_pkg::*;
(
  input wire logic [6:0] i_strobes,
  output ccdo_op_t o_op
);
  always_comb begin
    o_op = CCDO_OP_NONE;
    // lowest strobe wins if software ever raises two at once
    if (i_strobes[6]) o_op = CCDO_OP_DEC_SKIP;
    if (i_strobes[5]) o_op = CCDO_OP_CLEAR_ACC;
    if (i_strobes[4]) o_op = CCDO_OP_DECREMENT;
    if (i_strobes[3]) o_op = CCDO_OP_CLEAR_REG;
    if (i_strobes[2]) o_op = CCDO_OP_INVERT;
    if (i_strobes[1]) o_op = CCDO_OP_CALL;
    if (i_strobes[0]) o_op = CCDO_OP_WATCHDOG_CLEAR;
  end
endmodule

//--- testbench/ccdo_core_chk.sv
// timing checks on the ports of the clear/call/decrement slice
// assumes single-clock use with one-hot operation strobes
`timescale 1ns/1ps
module ccdo_core_chk
  import ccdo_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire logic I_WATCHDOG_CLEAR_OP,
  input wire logic I_CALL_OP,
  input wire logic I_CLEAR_REGISTER_OP,
  input wire logic I_CLEAR_ACCUMULATOR_OP,
  input wire logic I_DECREMENT_SKIP_ZERO_OP,
  input wire logic [7:0] I_REG_RDATA,
  input wire logic [7:0] I_PROGRAM_PAGE_LATCH,
  input wire logic [7:0] O_REG_WDATA,
  input wire logic [7:0] O_ACCUMULATOR,
  input wire logic [10:0] I_CALL_TARGET,
  input wire logic [12:0] I_PC,
  input wire logic [12:0] O_STACK_HEAD,
  input wire logic [12:0] O_PC_NEXT,
  input wire logic O_READY,
  input wire logic O_WATCHDOG_CLEAR,
  input wire logic O_WATCHDOG_EXPIRY_FLAG_SET,
  input wire logic O_DISCARD_NEXT,
  input wire logic O_SLEEP_ENTERED_FLAG_SET,
  input wire logic O_STACK_PUSH,
  input wire logic O_PC_LOAD,
  input wire logic O_REG_WE,
  input wire logic O_ZERO_FLAG_WE,
  input wire logic O_ZERO_FLAG
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  wire tk = I_VALID && O_READY;
  a_watchdog_clear_pulses: assert property (tk && I_WATCHDOG_CLEAR_OP |=> O_WATCHDOG_CLEAR &&
    O_WATCHDOG_EXPIRY_FLAG_SET && O_SLEEP_ENTERED_FLAG_SET) else $error("watchdog clear lost");
  a_call_push_head: assert property (tk && I_CALL_OP |=> O_STACK_PUSH &&
    O_STACK_HEAD == $past(I_PC) + 13'h0001) else $error("bad return address");
  a_call_pc_load: assert property (tk && I_CALL_OP |=> O_PC_LOAD &&
    O_PC_NEXT == {$past(I_PROGRAM_PAGE_LATCH[4:3]), $past(I_CALL_TARGET)})
    else $error("bad call target");
  a_call_two_cycle: assert property (tk && I_CALL_OP |=>
    !O_READY && !O_ZERO_FLAG_WE ##1 O_READY) else $error("call length wrong");
  a_clrreg_zero: assert property (tk && I_CLEAR_REGISTER_OP |=> O_REG_WE &&
    O_REG_WDATA == 8'h00 && O_ZERO_FLAG) else $error("register clear wrong");
  a_clracc_zero: assert property (tk && I_CLEAR_ACCUMULATOR_OP |=>
    O_ACCUMULATOR == 8'h00 && O_ZERO_FLAG) else $error("accumulator clear wrong");
  a_skip_no_flag: assert property (tk && I_DECREMENT_SKIP_ZERO_OP |=> !O_ZERO_FLAG_WE)
    else $error("skip touched zero flag");
  a_skip_taken: assert property (tk && I_DECREMENT_SKIP_ZERO_OP && I_REG_RDATA == 8'h01 |=>
    O_DISCARD_NEXT && !O_READY ##1 O_READY) else $error("skip not taken");
  a_refused_idle: assert property (I_VALID && !O_READY |=>
    !O_PC_LOAD && !O_REG_WE && !O_STACK_PUSH) else $error("refused request acted");
  c_call: cover property (tk && I_CALL_OP);
  c_skip: cover property (O_DISCARD_NEXT);
  c_refused: cover property (I_VALID && !O_READY);
endmodule

bind ccdo_core ccdo_core_chk u_ccdo_core_chk (.I_CLOCK, .I_RST, .I_VALID,
  .I_WATCHDOG_CLEAR_OP, .I_CALL_OP, .I_CLEAR_REGISTER_OP, .I_CLEAR_ACCUMULATOR_OP,
  .I_DECREMENT_SKIP_ZERO_OP, .I_REG_RDATA, .I_PROGRAM_PAGE_LATCH, .O_REG_WDATA,
  .O_ACCUMULATOR, .I_CALL_TARGET, .I_PC, .O_STACK_HEAD, .O_PC_NEXT, .O_READY,
  .O_WATCHDOG_CLEAR, .O_WATCHDOG_EXPIRY_FLAG_SET, .O_DISCARD_NEXT,
  .O_SLEEP_ENTERED_FLAG_SET, .O_STACK_PUSH, .O_PC_LOAD, .O_REG_WE, .O_ZERO_FLAG_WE,
  .O_ZERO_FLAG);

//--- testbench/cpu_clear_call_decrement_ops_bench.sv
// self-checking bench for the clear/call/decrement slice
// assumes effects show just after the taking edge, one cycle after the request is driven
`timescale 1ns/1ps
module cpu_clear_call_decrement_ops_bench;
  import ccdo_pkg::*;
  logic I_CLOCK = 1'b0, I_RST = 1'b1, I_VALID = 1'b0, I_DEST = 1'b0;
  logic [6:0] st = 7'h00, I_REG_ADDR = 7'h00;
  logic [10:0] I_CALL_TARGET = 11'h000;
  logic [7:0] I_REG_RDATA = 8'h00, I_PROGRAM_PAGE_LATCH = 8'h00, acc_e, r;
  logic [12:0] I_PC = 13'h0000;
  logic O_READY, O_DISCARD_NEXT, O_REG_WE, O_ZERO_FLAG_WE, O_ZERO_FLAG, O_WATCHDOG_CLEAR;
  logic O_WATCHDOG_EXPIRY_FLAG_SET, O_SLEEP_ENTERED_FLAG_SET, O_STACK_PUSH, O_PC_LOAD, z_e;
  logic [6:0] O_REG_WADDR;
  logic [7:0] O_REG_WDATA, O_ACCUMULATOR;
  logic [12:0] O_STACK_HEAD, O_PC_NEXT;
  int mismatches = 0, compares = 0;
  ccdo_core u_ccdo_core (.I_CLOCK, .I_RST, .I_VALID, .I_WATCHDOG_CLEAR_OP(st[0]),
    .I_CALL_OP(st[1]), .I_INVERT_REGISTER_OP(st[2]), .I_CLEAR_REGISTER_OP(st[3]),
    .I_DECREMENT_OP(st[4]), .I_CLEAR_ACCUMULATOR_OP(st[5]), .I_DECREMENT_SKIP_ZERO_OP(st[6]),
    .I_DEST, .I_REG_ADDR, .I_CALL_TARGET, .I_REG_RDATA, .I_PROGRAM_PAGE_LATCH, .I_PC,
    .O_READY, .O_DISCARD_NEXT, .O_REG_WE, .O_REG_WADDR, .O_REG_WDATA, .O_ACCUMULATOR,
    .O_ZERO_FLAG_WE, .O_ZERO_FLAG, .O_WATCHDOG_CLEAR, .O_WATCHDOG_EXPIRY_FLAG_SET,
    .O_SLEEP_ENTERED_FLAG_SET, .O_STACK_PUSH, .O_STACK_HEAD, .O_PC_LOAD, .O_PC_NEXT);
  always #12.5 I_CLOCK = ~I_CLOCK;
  function automatic logic [7:0] exp_res(input int k, input logic [7:0] v);
    if (k == 2) return ~v;
    if (k == 4 || k == 6) return v - 8'h01;
    return 8'h00;
  endfunction
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [12:0] a, input logic [12:0] b);
    compares++;
    if (a !== b) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, a, b);
    end
  endtask
  // keep holds the request one more cycle, where it must be refused
  task automatic do_op(input int k, input logic d, input logic [7:0] v, input bit keep);
    logic wr;
    @(posedge I_CLOCK);
    st <= 7'h01 << k;
    I_VALID <= 1'b1;
    I_DEST <= d;
    I_REG_RDATA <= v;
    I_PC <= 13'($urandom);
    I_REG_ADDR <= 7'($urandom);
    I_CALL_TARGET <= 11'($urandom);
    I_PROGRAM_PAGE_LATCH <= 8'($urandom);
    @(posedge I_CLOCK);
    I_VALID <= keep;
    #1;
    r = exp_res(k, v);
    wr = (k == 3) || (k != 5 && d);
    if (k == 0) begin
      chk(O_WATCHDOG_CLEAR & O_WATCHDOG_EXPIRY_FLAG_SET & O_SLEEP_ENTERED_FLAG_SET, 1'b1);
      chk(O_ZERO_FLAG_WE, 1'b0);
    end else if (k == 1) begin
      chk(O_STACK_HEAD, I_PC + 13'h0001);
      chk(O_PC_NEXT, {I_PROGRAM_PAGE_LATCH[4:3], I_CALL_TARGET});
      chk(O_READY, 1'b0);
    end else begin
      chk(O_REG_WE, wr);
      if (wr) begin
        chk(O_REG_WADDR, I_REG_ADDR);
        chk(O_REG_WDATA, r);
      end else begin
        acc_e = r;
      end
      chk(O_ZERO_FLAG_WE, k != 6);
      chk(O_ACCUMULATOR, acc_e);
      if (k != 6) z_e = (r == 8'h00);
      chk(O_ZERO_FLAG, z_e);
      chk(O_DISCARD_NEXT, k == 6 && r == 8'h00);
    end
    if (keep) begin
      @(posedge I_CLOCK);
      I_VALID <= 1'b0;
      #1 chk({O_READY, O_PC_LOAD, O_REG_WE}, 3'h4);
    end
  endtask
  initial begin
    acc_e = 8'h00;
    z_e = 1'b0;
    void'($urandom(72));
    repeat (6) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    #1 chk({O_READY, O_ACCUMULATOR, O_ZERO_FLAG}, 10'h200);
    do_op(1, 1'b0, 8'h00, 1'b1);
    do_op(6, 1'b1, 8'h01, 1'b1);
    do_op(4, 1'b0, 8'h00, 1'b0);
    do_op(2, 1'b0, 8'hFF, 1'b0);
    do_op(0, 1'b0, 8'h00, 1'b0);
    do_op(3, 1'b0, 8'h5A, 1'b0);
    do_op(4, 1'b1, 8'h01, 1'b0);
    do_op(5, 1'b1, 8'hA5, 1'b0);
    do_op(6, 1'b0, 8'h00, 1'b0);
    $display("test corner done");
    repeat (80) do_op($urandom % 7, 1'($urandom), 8'($urandom), 1'b0);
    $display("test random done");
    print_verdict;
  end
  // generous bound: the whole sequence needs well under 400 cycles
  initial begin
    #50000;
    mismatches++;
    print_verdict;
  end
endmodule
